/* File: logic/frontend_switch_select.sv */
`timescale 1ns/10ps
`default_nettype none
module frontend_switch_select (
  // Mode select
  input  wire logic                       manual_mode,
  // Competing switch requests
  input  wire led_afe_pkg::switch_type    manual_req,
  input  wire led_afe_pkg::switch_type    seq_req,
  // Resulting switch settings
  output led_afe_pkg::analog_sw_type      sw
);
  led_afe_pkg::switch_type pick;

  // Software owns the switches only in manual mode
  always_comb begin
    if (manual_mode) begin
      pick = manual_req;                                 // see [R8]
    end else begin
      pick = seq_req;                                    // see [R13]
    end
    sw.integrator_short = ~pick.integrator_run;          // see [R9] see [R10]
    sw.pin_connect      = pick.output_connect;           // see [R11] see [R12]
  end
endmodule
`default_nettype wire

/* File: logic/led_afe_pkg.sv */
`default_nettype none
package led_afe_pkg;

  // Channel shape
  localparam int CH_N   = 4;
  localparam int CODE_W = 8;
  localparam int FS_W   = 2;
  localparam int CUR_W  = 17;

  // Register byte offsets
  localparam logic [7:0] OFF_CFG  = 8'h00;
  localparam logic [7:0] OFF_CURR = 8'h04;
  localparam logic [7:0] OFF_MAN  = 8'h20;

  // Field positions
  localparam int SIGREF_BIT   = 18;
  localparam int SOURCE_LSB   = 8;
  localparam int FS_LSB       = 0;
  localparam int MAN_MODE_BIT = 26;
  localparam int INTEG_BIT    = 23;
  localparam int CONN_LSB     = 19;

  // Writable bits and reset values
  localparam logic [31:0] CFG_MASK  = 32'h0004_0fff;
  localparam logic [31:0] CFG_RST   = 32'h0000_0055;
  localparam logic [31:0] CURR_MASK = 32'hffff_ffff;
  localparam logic [31:0] CURR_RST  = 32'h0000_0000;
  localparam logic [31:0] MAN_MASK  = 32'h04f8_0000;
  localparam logic [31:0] MAN_RST   = 32'h0000_0000;

  // Full-scale range codes and their currents in microamps
  localparam logic [FS_W-1:0]  FS_25  = 2'h0;
  localparam logic [FS_W-1:0]  FS_50  = 2'h1;
  localparam logic [FS_W-1:0]  FS_100 = 2'h2;
  localparam logic [CUR_W-1:0] UA_25  = 17'h0_61a8;
  localparam logic [CUR_W-1:0] UA_50  = 17'h0_c350;
  localparam logic [CUR_W-1:0] UA_100 = 17'h1_86a0;

  // Switch requests and switch settings
  typedef struct packed {
    logic       integrator_run;
    logic [3:0] output_connect;
  } switch_type;

  typedef struct packed {
    logic       integrator_short;
    logic [3:0] pin_connect;
  } analog_sw_type;

endpackage
`default_nettype wire

/* File: logic/led_afe_regs.sv */
// Register access over Wishbone was decided locally.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// [R1] Reference enable at bit 18, resets low
// [R2] Sink enables at bits 8..11, reset low
// [R3] Range codes 25, 50, 100 mA; 3 forbidden
// [R4] Range fields 7:6 down to 1:0, reset 1
// [R5] Four 8-bit current codes, reset zero
// [R6] Current equals (code+1) times range over 256
// [R7] Software avoids current code zero
// [R8] Bit 26 picks manual over sequencer
// [R9] Manual, bit 23 low: integrator shorted
// [R10] Manual, bit 23 high: integrator runs
// [R11] Manual, bit 22 connects D4 pin
// [R12] Manual, bits 21..19 connect D3..D1
// [R13] Sequencer mode ignores manual switch bits
// [R14] Unlisted bits read zero; fields read back
module led_afe_regs #(
  parameter int ADDR_W = 6
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o,
  // Sequencer switch requests
  input  wire logic              seq_integrator_run,
  input  wire logic [3:0]        seq_output_connect,
  // Analog front-end controls
  output logic              sigref_on,
  output logic [3:0]        sink_source_on,
  output logic [7:0]        sink_full_scale,
  output logic [31:0]       sink_current_code,
  output logic [67:0]       sink_current_ua,
  output logic              manual_mode,
  output logic              integrator_short,
  output logic [3:0]        sink_pin_connect
);
  localparam int CW = led_afe_pkg::CUR_W;

  logic [31:0]             cfg_q;
  logic [31:0]             cfg_d;
  logic [31:0]             curr_q;
  logic [31:0]             curr_d;
  logic [31:0]             man_q;
  logic [31:0]             man_d;
  logic                    ack_q;
  logic                    ack_d;
  logic [31:0]             rdat_q;
  logic [31:0]             rdat_d;
  logic [4*CW-1:0]         ua_q;
  logic [4*CW-1:0]         ua_d;
  led_afe_pkg::analog_sw_type sw_q;
  led_afe_pkg::analog_sw_type sw_d;
  led_afe_pkg::switch_type manual_req;
  led_afe_pkg::switch_type seq_req;
  logic                    req;
  logic                    commit;
  logic [ADDR_W-3:0]       word;
  logic                    hit_cfg;
  logic                    hit_curr;
  logic                    hit_man;

  // Merge byte lanes, then drop bits that do not exist
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  sel,
                                        input logic [31:0] mask);
    logic [31:0] lane;
    for (int i = 0; i < 4; i++) begin
      lane[i*8 +: 8] = {8{sel[i]}};
    end
    return ((old & ~lane) | (dat & lane)) & mask;   // see [R14]
  endfunction

  // Address decode on word boundaries
  assign req      = wb_cyc_i & wb_stb_i;
  assign commit   = req & ack_q & wb_we_i;
  assign word     = wb_adr_i[ADDR_W-1:2];
  assign hit_cfg  = word == led_afe_pkg::OFF_CFG[ADDR_W-1:2];
  assign hit_curr = word == led_afe_pkg::OFF_CURR[ADDR_W-1:2];
  assign hit_man  = word == led_afe_pkg::OFF_MAN[ADDR_W-1:2];

  // Bus answer: one wait state, so the ack is a clean flop
  always_comb begin
    ack_d  = req & ~ack_q;
    rdat_d = 32'h0000_0000;
    if (req & ~ack_q) begin
      if (hit_cfg) begin
        rdat_d = cfg_q;                             // see [R14]
      end else if (hit_curr) begin
        rdat_d = curr_q;
      end else if (hit_man) begin
        rdat_d = man_q;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // Writes land on the ack edge, when the master sees it too
  always_comb begin
    cfg_d  = cfg_q;
    curr_d = curr_q;
    man_d  = man_q;
    if (commit) begin
      if (hit_cfg) begin
        cfg_d = merge(cfg_q, wb_dat_i, wb_sel_i, led_afe_pkg::CFG_MASK);     // see [R1] see [R2] see [R4]
      end
      if (hit_curr) begin
        curr_d = merge(curr_q, wb_dat_i, wb_sel_i, led_afe_pkg::CURR_MASK);  // see [R5]
      end
      if (hit_man) begin
        man_d = merge(man_q, wb_dat_i, wb_sel_i, led_afe_pkg::MAN_MASK);     // see [R8]
      end
    end
  end

  // Register file; unmapped writes are acked and dropped
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_q  <= led_afe_pkg::CFG_RST;               // see [R4]
      curr_q <= led_afe_pkg::CURR_RST;              // see [R5]
      man_q  <= led_afe_pkg::MAN_RST;
    end else begin
      cfg_q  <= cfg_d;
      curr_q <= curr_d;
      man_q  <= man_d;
    end
  end

  // Per-channel target current
  for (genvar ch = 0; ch < led_afe_pkg::CH_N; ch++) begin : g_sink
    sink_current_calc #(
      .CODE_W (led_afe_pkg::CODE_W),
      .CUR_W  (CW)
    ) u_calc (
      .code       (curr_q[ch*8 +: 8]),
      .full_scale (cfg_q[led_afe_pkg::FS_LSB + ch*2 +: 2]),
      .current_ua (ua_d[ch*CW +: CW])
    );
  end

  // Gather both switch requests
  assign manual_req.integrator_run = man_q[led_afe_pkg::INTEG_BIT];
  assign manual_req.output_connect = man_q[led_afe_pkg::CONN_LSB +: 4];
  assign seq_req.integrator_run    = seq_integrator_run;
  assign seq_req.output_connect    = seq_output_connect;

  frontend_switch_select u_switch (
    .manual_mode (man_q[led_afe_pkg::MAN_MODE_BIT]),
    .manual_req  (manual_req),
    .seq_req     (seq_req),
    .sw          (sw_d)
  );

  // Analog controls are flopped so glitches never reach the sinks
  always_ff @(posedge mclk) begin
    if (rst) begin
      ua_q                  <= '0;
      sw_q.integrator_short <= 1'b1;                // Safe: integrator held in reset
      sw_q.pin_connect      <= 4'h0;
    end else begin
      ua_q <= ua_d;                                 // see [R6]
      sw_q <= sw_d;                                 // see [R13]
    end
  end

  // Outputs are register bits
  assign wb_ack_o          = ack_q;
  assign wb_dat_o          = rdat_q;
  assign sigref_on         = cfg_q[led_afe_pkg::SIGREF_BIT];     // see [R1]
  assign sink_source_on    = cfg_q[led_afe_pkg::SOURCE_LSB +: 4]; // see [R2]
  assign sink_full_scale   = cfg_q[led_afe_pkg::FS_LSB +: 8];
  assign sink_current_code = curr_q;
  assign sink_current_ua   = ua_q;
  assign manual_mode       = man_q[led_afe_pkg::MAN_MODE_BIT];
  assign integrator_short  = sw_q.integrator_short;
  assign sink_pin_connect  = sw_q.pin_connect;

  // Bus handshake checks
  a_ack_single_pulse: assert property (@(posedge mclk) disable iff (rst) // see [R14]
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_ack_after_request: assert property (@(posedge mclk) disable iff (rst) // see [R14]
    (req && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered in one cycle");

  a_read_idle_zero: assert property (@(posedge mclk) disable iff (rst) // see [R14]
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data present without ack");

  // Reset values seen at release
  a_reset_values: assert property (@(posedge mclk) // see [R1] see [R4] see [R5]
    rst |=> (cfg_q == 32'h0000_0055) && (curr_q == 32'h0000_0000)
            && !manual_mode && !sigref_on)
    else $error("register reset value wrong");

  a_switch_reset: assert property (@(posedge mclk) // see [R11]
    rst |=> integrator_short && (sink_pin_connect == 4'h0))
    else $error("switch reset value wrong");

  a_current_reset: assert property (@(posedge mclk) // see [R6]
    rst |=> sink_current_ua == 68'h0)
    else $error("sink current not cleared by reset");

  // Fields follow their writes and hold otherwise
  a_sigref_write: assert property (@(posedge mclk) disable iff (rst) // see [R1]
    (commit && hit_cfg && wb_sel_i[2])
    |=> sigref_on == $past(wb_dat_i[18]))
    else $error("reference enable did not take the write");

  a_source_write: assert property (@(posedge mclk) disable iff (rst) // see [R2]
    (commit && hit_cfg && wb_sel_i[1])
    |=> sink_source_on == $past(wb_dat_i[11:8]))
    else $error("sink enables did not take the write");

  a_range_write: assert property (@(posedge mclk) disable iff (rst) // see [R4]
    (commit && hit_cfg && wb_sel_i[0])
    |=> sink_full_scale == $past(wb_dat_i[7:0]))
    else $error("range fields did not take the write");

  a_lane_keeps_range: assert property (@(posedge mclk) disable iff (rst) // see [R4]
    (commit && hit_cfg && !wb_sel_i[0]) |=> $stable(sink_full_scale))
    else $error("unselected lane changed the range fields");

  a_code_write: assert property (@(posedge mclk) disable iff (rst) // see [R5]
    (commit && hit_curr && wb_sel_i[3])
    |=> sink_current_code[31:24] == $past(wb_dat_i[31:24]))
    else $error("channel four code did not take the write");

  a_mode_write: assert property (@(posedge mclk) disable iff (rst) // see [R8]
    (commit && hit_man && wb_sel_i[3])
    |=> manual_mode == $past(wb_dat_i[26]))
    else $error("override mode did not take the write");

  a_source_hold: assert property (@(posedge mclk) disable iff (rst) // see [R2]
    !(commit && hit_cfg) |=> $stable(sink_source_on))
    else $error("sink enables changed without a write");

  a_code_hold: assert property (@(posedge mclk) disable iff (rst) // see [R5]
    !(commit && hit_curr) |=> $stable(sink_current_code))
    else $error("current codes changed without a write");

  a_mode_hold: assert property (@(posedge mclk) disable iff (rst) // see [R8]
    !(commit && hit_man) |=> $stable(manual_mode))
    else $error("override mode changed without a write");

  // Readback matches the stored fields
  a_cfg_readback: assert property (@(posedge mclk) disable iff (rst) // see [R14]
    (wb_ack_o && !wb_we_i && hit_cfg) |-> wb_dat_o == cfg_q)
    else $error("config read data wrong");

  a_curr_readback: assert property (@(posedge mclk) disable iff (rst) // see [R5]
    (wb_ack_o && !wb_we_i && hit_curr) |-> wb_dat_o == curr_q)
    else $error("current read data wrong");

  a_man_readback: assert property (@(posedge mclk) disable iff (rst) // see [R14]
    (wb_ack_o && !wb_we_i && hit_man) |-> wb_dat_o == man_q)
    else $error("override read data wrong");

  a_cfg_reserved: assert property (@(posedge mclk) disable iff (rst) // see [R14]
    (wb_ack_o && hit_cfg) |-> (wb_dat_o & ~led_afe_pkg::CFG_MASK) == 32'h0000_0000)
    else $error("config reserved bits read nonzero");

  a_reserved_zero: assert property (@(posedge mclk) disable iff (rst) // see [R14]
    (wb_ack_o && hit_man) |-> (wb_dat_o & 32'hfb07_ffff) == 32'h0000_0000)
    else $error("reserved bits read nonzero");

  a_unmapped_zero: assert property (@(posedge mclk) disable iff (rst) // see [R14]
    (wb_ack_o && !hit_cfg && !hit_curr && !hit_man) |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read returned data");

  a_read_no_change: assert property (@(posedge mclk) disable iff (rst) // see [R14]
    (req && !wb_we_i)
    |=> $stable(cfg_q) && $stable(curr_q) && $stable(man_q))
    else $error("read disturbed a register");

  a_unmapped_write_drop: assert property (@(posedge mclk) disable iff (rst) // see [R14]
    (commit && !hit_cfg && !hit_curr && !hit_man)
    |=> $stable(cfg_q) && $stable(curr_q) && $stable(man_q))
    else $error("unmapped write reached a register");

  // Current formula at chosen codes
  a_full_code_50: assert property (@(posedge mclk) disable iff (rst) // see [R6]
    (curr_q[7:0] == 8'hff && cfg_q[1:0] == 2'h1)
    |=> sink_current_ua[16:0] == 17'h0_c350)
    else $error("full code at 50 mA range wrong");

  a_full_code_100: assert property (@(posedge mclk) disable iff (rst) // see [R3] see [R6]
    (curr_q[7:0] == 8'hff && cfg_q[1:0] == 2'h2)
    |=> sink_current_ua[16:0] == 17'h1_86a0)
    else $error("full code at 100 mA range wrong");

  a_low_code_100: assert property (@(posedge mclk) disable iff (rst) // see [R6]
    (curr_q[15:8] == 8'h01 && cfg_q[3:2] == 2'h2)
    |=> sink_current_ua[33:17] == 17'h0_030d)
    else $error("low code at 100 mA range wrong");

  a_low_code_25: assert property (@(posedge mclk) disable iff (rst) // see [R6]
    (curr_q[15:8] == 8'h01 && cfg_q[3:2] == 2'h0)
    |=> sink_current_ua[33:17] == 17'h0_00c3)
    else $error("low code at 25 mA range wrong");

  a_mid_code_50: assert property (@(posedge mclk) disable iff (rst) // see [R6]
    (curr_q[23:16] == 8'h80 && cfg_q[5:4] == 2'h1)
    |=> sink_current_ua[50:34] == 17'h0_626b)
    else $error("mid code at 50 mA range wrong");

  a_mid_code_100: assert property (@(posedge mclk) disable iff (rst) // see [R6]
    (curr_q[23:16] == 8'h80 && cfg_q[5:4] == 2'h2)
    |=> sink_current_ua[50:34] == 17'h0_c4d6)
    else $error("mid code at 100 mA range wrong");

  a_range_25_full: assert property (@(posedge mclk) disable iff (rst) // see [R3]
    (curr_q[31:24] == 8'hff && cfg_q[7:6] == 2'h0)
    |=> sink_current_ua[67:51] == 17'h0_61a8)
    else $error("full code at 25 mA range wrong");

  // Switch ownership
  a_manual_integrator: assert property (@(posedge mclk) disable iff (rst) // see [R9] see [R10]
    manual_mode |=> integrator_short == !$past(man_q[23]))
    else $error("manual integrator switch wrong");

  a_manual_outputs: assert property (@(posedge mclk) disable iff (rst) // see [R11] see [R12]
    manual_mode |=> sink_pin_connect == $past(man_q[22:19]))
    else $error("manual output switch wrong");

  a_sequencer_owns: assert property (@(posedge mclk) disable iff (rst) // see [R8] see [R13]
    !manual_mode |=> (sink_pin_connect == $past(seq_output_connect))
                     && (integrator_short == !$past(seq_integrator_run)))
    else $error("sequencer lost switch control");

endmodule
`default_nettype wire

/* File: logic/sink_current_calc.sv */
`timescale 1ns/10ps
`default_nettype none
module sink_current_calc #(
  parameter int CODE_W = 8,
  parameter int CUR_W  = 17
) (
  // Channel settings
  input  wire logic [CODE_W-1:0] code,
  input  wire logic [1:0]        full_scale,
  // Target sink current in microamps
  output logic [CUR_W-1:0]  current_ua
);
  logic [CUR_W-1:0]        range_ua;
  logic [CUR_W+CODE_W:0]   product;

  // Range lookup; the forbidden code drives nothing rather than guess
  always_comb begin
    case (full_scale)
      led_afe_pkg::FS_25:  range_ua = led_afe_pkg::UA_25;
      led_afe_pkg::FS_50:  range_ua = led_afe_pkg::UA_50;
      led_afe_pkg::FS_100: range_ua = led_afe_pkg::UA_100;
      default:             range_ua = '0;              // see [R3]
    endcase
  end

  // (code + 1) * range / 256
  assign product    = ({1'b0, code} + 1'b1) * range_ua;           // see [R6]
  assign current_ua = product[CUR_W+CODE_W-1:CODE_W];
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // Design inputs, all driven by the bench
  logic        mclk;
  logic        rst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [5:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic        seq_run;
  logic [3:0]  seq_conn;
  // Design outputs
  logic [31:0] dat_o;
  logic        ack;
  logic        sigref_on;
  logic [3:0]  source_on;
  logic [7:0]  full_scale;
  logic [31:0] code;
  logic [67:0] ua;
  logic        manual_mode;
  logic        integ_short;
  logic [3:0]  pin_connect;
  // Bookkeeping
  int          errors;
  int          check_count;
  int          cycles;
  logic [31:0] rd;

  led_afe_regs i_led_afe_regs (
    .mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .seq_integrator_run(seq_run), .seq_output_connect(seq_conn), .sigref_on(sigref_on),
    .sink_source_on(source_on), .sink_full_scale(full_scale), .sink_current_code(code),
    .sink_current_ua(ua), .manual_mode(manual_mode), .integrator_short(integ_short),
    .sink_pin_connect(pin_connect)
  );

  // 40 MHz clock
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  // Hang guard; the whole sequence needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [67:0] seen, input logic [67:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Classic single cycle; data taken only at the edge that samples ack
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                         output logic [31:0] r);
    @(posedge mclk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a[5:0];
    sel  <= s;
    wdat <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  // Derived outputs lag a write by one more edge
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask

  function automatic logic [16:0] exp_ua(input logic [7:0] c, input logic [1:0] fs);
    logic [31:0] range;
    range = (fs == led_afe_pkg::FS_25) ? 32'(led_afe_pkg::UA_25) :
            (fs == led_afe_pkg::FS_50) ? 32'(led_afe_pkg::UA_50) :
            (fs == led_afe_pkg::FS_100) ? 32'(led_afe_pkg::UA_100) : 32'h0000_0000;
    return 17'(((32'(c) + 1) * range) >> 8);
  endfunction

  // Bench current codes; no channel gets the dead code zero
  localparam logic [31:0] CUR_VAL = 32'hff80_01ff;

  task automatic reset_values();
    #1;
    check(sigref_on, 1'b0, "sigref reset");
    check(source_on, 4'h0, "source reset");
    check(full_scale, 8'h55, "range reset");
    check(code, 32'h0000_0000, "code reset");
    check(manual_mode, 1'b0, "mode reset");
    check({integ_short, pin_connect}, 5'h10, "switch reset");
    check(ua, 68'h0, "current reset");
    wb_xfer(1'b0, led_afe_pkg::OFF_CFG, 32'h0000_0000, 4'hf, rd);
    check(rd, led_afe_pkg::CFG_RST, "config read reset");
    wb_xfer(1'b0, led_afe_pkg::OFF_MAN, 32'h0000_0000, 4'hf, rd);
    check(rd, led_afe_pkg::MAN_RST, "manual read reset");
  endtask

  task automatic cfg_fields();
    wb_xfer(1'b1, led_afe_pkg::OFF_CFG, 32'hffff_ffaa, 4'hf, rd);
    wb_xfer(1'b0, led_afe_pkg::OFF_CFG, 32'h0000_0000, 4'hf, rd);
    check(rd, 32'h0004_0faa, "config unlisted bits");
    settle();
    check(sigref_on, 1'b1, "sigref set");
    check(source_on, 4'hf, "sources on");
    check(full_scale, 8'haa, "range set");
    // Byte lane writes clear one field without touching the others
    wb_xfer(1'b1, led_afe_pkg::OFF_CFG, 32'h0000_0000, 4'h2, rd);
    wb_xfer(1'b1, led_afe_pkg::OFF_CFG, 32'h0000_0000, 4'h4, rd);
    wb_xfer(1'b0, led_afe_pkg::OFF_CFG, 32'h0000_0000, 4'hf, rd);
    check(rd, 32'h0000_00aa, "config lanes");
    settle();
    check(sigref_on, 1'b0, "sigref clear");
    check(source_on, 4'h0, "sources off");
  endtask

  task automatic current_calc();
    wb_xfer(1'b1, led_afe_pkg::OFF_CURR, CUR_VAL, 4'hf, rd);
    wb_xfer(1'b0, led_afe_pkg::OFF_CURR, 32'h0000_0000, 4'hf, rd);
    check(rd, CUR_VAL, "current readback");
    check(code, CUR_VAL, "current codes out");
    // Range code 3 is never written by software
    for (int fs = 0; fs < 3; fs++) begin
      wb_xfer(1'b1, led_afe_pkg::OFF_CFG, {24'h00_0000, {4{2'(fs)}}}, 4'hf, rd);
      settle();
      check(full_scale, {4{2'(fs)}}, "range fields");
      for (int ch = 0; ch < 4; ch++)
        check(ua[ch*17 +: 17], exp_ua(CUR_VAL[ch*8 +: 8], 2'(fs)), "sink current");
    end
  endtask

  task automatic manual_override();
    @(posedge mclk);
    seq_run  <= 1'b1;
    seq_conn <= 4'ha;
    settle();
    check({integ_short, pin_connect}, 5'h0a, "sequencer path");
    wb_xfer(1'b1, led_afe_pkg::OFF_MAN, 32'h0400_0000, 4'hf, rd);
    settle();
    check(manual_mode, 1'b1, "manual mode");
    check({integ_short, pin_connect}, 5'h10, "manual shorted");
    @(posedge mclk);
    seq_run <= 1'b0;
    wb_xfer(1'b1, led_afe_pkg::OFF_MAN, 32'h04c8_0000, 4'hf, rd);
    settle();
    check({integ_short, pin_connect}, 5'h09, "manual run");
    wb_xfer(1'b1, led_afe_pkg::OFF_MAN, 32'hffff_ffff, 4'hf, rd);
    wb_xfer(1'b0, led_afe_pkg::OFF_MAN, 32'h0000_0000, 4'hf, rd);
    check(rd, led_afe_pkg::MAN_MASK, "manual unlisted bits");
    settle();
    check(pin_connect, 4'hf, "manual pins");
    // Switch bits left set must be ignored once back in sequencer mode
    wb_xfer(1'b1, led_afe_pkg::OFF_MAN, 32'h00f8_0000, 4'hf, rd);
    seq_conn <= 4'h6;
    settle();
    check({integ_short, pin_connect}, 5'h16, "sequencer again");
  endtask

  task automatic unmapped();
    wb_xfer(1'b1, 8'h10, 32'hffff_ffff, 4'hf, rd);
    wb_xfer(1'b0, 8'h10, 32'h0000_0000, 4'hf, rd);
    check(rd, 32'h0000_0000, "unmapped read");
    wb_xfer(1'b0, led_afe_pkg::OFF_CURR, 32'h0000_0000, 4'hf, rd);
    check(rd, CUR_VAL, "current untouched");
  endtask

  initial begin
    errors = 0;
    check_count = 0;
    cycles = 0;
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 6'h00;
    sel = 4'h0;
    wdat = 32'h0000_0000;
    seq_run = 1'b0;
    seq_conn = 4'h0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    reset_values();
    cfg_fields();
    current_calc();
    manual_override();
    unmapped();
    conclude();
  end
endmodule
`default_nettype wire
